// >>> stack_seq_pkg.sv
// Constants, types and small decode functions for the stack and block move bus sequencer.
// Assumes one processor clock and that the core hands over register values at start.
package stack_seq_pkg;

  typedef enum logic [3:0] {
    op_return_long, op_push, op_pull, op_push_indirect, op_push_absolute,
    op_push_relative, op_stack_rel, op_stack_rel_ind, op_block_move_descending
  } op_type;

  typedef enum logic [3:0] {
    st_idle, st_fetch, st_opf, st_io, st_ptr, st_data, st_bank, st_next, st_mvrd, st_mvwr
  } state_type;

  localparam logic [1:0] WIDTH_8 = 2'h0;
  localparam logic [1:0] WIDTH_16 = 2'h1;
  localparam logic [1:0] WIDTH_32 = 2'h2;
  localparam logic [7:0] STACK_BANK = 8'h00;
  localparam logic [15:0] RTL_BANK_OFFSET = 16'h0003;
  localparam logic [15:0] PER_INSN_LEN = 16'h0003;
  localparam logic [15:0] MOVE_NEXT_EMU = 16'h0003;
  localparam logic [15:0] MOVE_NEXT_NATIVE = 16'h0001;
  localparam logic [2:0] PTR_BYTES = 3'h2;

  // Bytes carried by one data access for a width code.
  function automatic logic [2:0] width_bytes(input logic [1:0] w);
    case (w)
      WIDTH_16: width_bytes = 3'h2;
      WIDTH_32: width_bytes = 3'h4;
      default: width_bytes = 3'h1;
    endcase
  endfunction : width_bytes

  // Byte i of a 32-bit word, byte zero least significant.
  function automatic logic [7:0] byte_of(input logic [31:0] v, input logic [1:0] i);
    logic [31:0] t;
    t = v >> {i, 3'b000};
    byte_of = t[7:0];
  endfunction : byte_of

endpackage : stack_seq_pkg

// >>> stack_block_move_bus_sequencer.sv
// Bus sequencer for the stack instructions, stack relative modes and the descending block move.
// Assumes read data comes from memory on the same clock, valid in the cycle it is addressed.
`timescale 1ns/100ps
module stack_block_move_bus_sequencer (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic start,
  input wire stack_seq_pkg::op_type op,
  input wire logic [1:0] width,
  input wire logic store,
  input wire logic native,
  input wire logic [15:0] pc_in,
  input wire logic [15:0] sp_in,
  input wire logic [15:0] direct_in,
  input wire logic [31:0] x_in,
  input wire logic [31:0] y_in,
  input wire logic [31:0] acc_in,
  input wire logic [7:0] pbank_in,
  input wire logic [7:0] dbank_in,
  input wire logic [15:0] move_banks_in,
  input wire logic [31:0] reg_in,
  input wire logic [7:0] rdata,
  output logic busy,
  output logic done,
  output logic [23:0] bus_addr,
  output logic [7:0] wdata,
  output logic read_not_write,
  output logic data_valid_out,
  output logic program_valid_out,
  output logic vector_pull_out,
  output logic memory_lock_out,
  output logic [15:0] sp_out,
  output logic [31:0] x_out,
  output logic [31:0] y_out,
  output logic [31:0] acc_out,
  output logic [7:0] pbank_out,
  output logic [31:0] result_out
);
  import stack_seq_pkg::*;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  state_type state_q, io_next_q;
  op_type op_q;
  logic [2:0] n_q;
  logic [1:0] k_q, m_q, io_left_q;
  logic [23:0] io_addr_q, base_q;
  logic down_q, wr_q, native_q, done_q;
  logic [15:0] pc_q, sp_q, dir_q, off_q, pc_next_q;
  logic [31:0] x_q, y_q, acc_q, push_val_q, reg_q, result_q;
  logic [7:0] pbank_q, dbank_q, sbank_q, mdst_q, ptr_q, mv_byte_q;

  ////////////////////////////////////////////////////////////////////////////////
  wire logic [2:0] k_next = {1'b0, k_q} + 3'h1;
  wire logic data_last = (k_next == n_q);
  wire logic opf_last = (k_next == {1'b0, m_q});
  wire logic [15:0] off_full = (k_q == 2'h0) ? {off_q[15:8], rdata} : {rdata, off_q[7:0]};
  wire logic [15:0] ptr_full = {rdata, ptr_q};
  wire logic [15:0] n16 = {13'h0000, n_q};
  wire logic [23:0] k24 = {22'h000000, k_q};
  wire logic [23:0] data_addr = down_q ? base_q - k24 : base_q + k24;
  wire logic [2:0] push_idx = n_q - 3'h1 - {1'b0, k_q};
  wire logic [7:0] data_byte = down_q ? byte_of(push_val_q, push_idx[1:0]) : byte_of(reg_q, k_q);
  wire logic is_push = (op == op_push) || (op == op_push_indirect) ||
                       (op == op_push_absolute) || (op == op_push_relative);
  wire logic in_data = (state_q == st_data);

  // Bus address, direction and qualifiers decode straight from the state registers.
  assign bus_addr = (state_q == st_fetch) ? {pbank_q, pc_q} :
                    (state_q == st_opf) ? {pbank_q, pc_q + 16'h0001 + {14'h0000, k_q}} :
                    (state_q == st_io) ? io_addr_q :
                    (state_q == st_ptr) ? base_q + k24 :
                    in_data ? data_addr :
                    (state_q == st_bank) ? {STACK_BANK, sp_q + RTL_BANK_OFFSET} :
                    (state_q == st_next) ? {pbank_q, pc_next_q} :
                    (state_q == st_mvrd) ? {sbank_q, x_q[15:0]} :
                    (state_q == st_mvwr) ? {mdst_q, y_q[15:0]} : 24'h000000;
  assign read_not_write = !((in_data && wr_q) || (state_q == st_mvwr));
  assign wdata = (state_q == st_mvwr) ? mv_byte_q : (in_data && wr_q) ? data_byte : 8'h00;
  assign data_valid_out = (state_q == st_fetch) || in_data || (state_q == st_ptr) ||
                          (state_q == st_bank) || (state_q == st_next) ||
                          (state_q == st_mvrd) || (state_q == st_mvwr);
  assign program_valid_out = (state_q == st_fetch) || (state_q == st_opf) ||
                             (state_q == st_next);
  // The sequencer never pulls vectors and never locks, so both stay at their idle level.
  assign vector_pull_out = 1'b1;
  assign memory_lock_out = 1'b1;
  assign busy = (state_q != st_idle);
  assign done = done_q;
  assign sp_out = sp_q;
  assign x_out = x_q;
  assign y_out = y_q;
  assign acc_out = acc_q;
  assign pbank_out = pbank_q;
  assign result_out = result_q;

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= st_idle;
      io_next_q <= st_idle;
      op_q <= op_push;
      {n_q, k_q, m_q, io_left_q} <= 9'h000;
      {io_addr_q, base_q} <= 48'h000000000000;
      {down_q, wr_q, native_q, done_q} <= 4'h0;
      {pc_q, sp_q, dir_q, off_q, pc_next_q} <= 80'h00000000000000000000;
      {x_q, y_q, acc_q} <= 96'h000000000000000000000000;
      {push_val_q, reg_q, result_q} <= 96'h000000000000000000000000;
      {pbank_q, dbank_q, sbank_q, mdst_q, ptr_q, mv_byte_q} <= 48'h000000000000;
    end else begin
      done_q <= 1'b0;
      case (state_q)
        st_idle: if (start) begin
          op_q <= op;
          {pc_q, sp_q, dir_q} <= {pc_in, sp_in, direct_in};
          {x_q, y_q, acc_q} <= {x_in, y_in, acc_in};
          {pbank_q, dbank_q, mdst_q, sbank_q} <= {pbank_in, dbank_in, move_banks_in};
          reg_q <= reg_in;
          push_val_q <= reg_in;
          result_q <= 32'h00000000;
          n_q <= width_bytes(width);
          native_q <= native;
          wr_q <= store || is_push;
          down_q <= is_push;
          k_q <= 2'h0;
          base_q <= {STACK_BANK, (op == op_pull) ? sp_in + 16'h0001 : sp_in};
          m_q <= (op == op_push_indirect || op == op_stack_rel || op == op_stack_rel_ind) ?
                 2'h1 : 2'h2;
          state_q <= (op == op_return_long) ? st_bank : st_fetch;
        end
        st_fetch: begin
          k_q <= 2'h0;
          io_addr_q <= {pbank_q, pc_q + 16'h0001};
          io_next_q <= st_data;
          case (op_q)
            op_push: {io_left_q, state_q} <= {2'h1, st_io};
            op_pull: {io_left_q, state_q} <= {2'h2, st_io};
            op_block_move_descending: state_q <= native_q ? st_mvrd : st_opf;
            default: state_q <= st_opf;
          endcase
        end
        st_opf: begin
          if (k_q == 2'h0) off_q[7:0] <= rdata;
          else off_q[15:8] <= rdata;
          k_q <= k_next[1:0];
          if (opf_last) begin
            k_q <= 2'h0;
            io_left_q <= 2'h1;
            io_addr_q <= {pbank_q, pc_q + 16'h0001};
            case (op_q)
              op_push_indirect: begin
                base_q <= {STACK_BANK, dir_q + {8'h00, rdata}};
                io_next_q <= st_ptr;
                state_q <= (dir_q[7:0] != 8'h00) ? st_io : st_ptr;
              end
              op_push_absolute: begin
                push_val_q <= {16'h0000, off_full};
                n_q <= PTR_BYTES;
                state_q <= st_data;
              end
              op_push_relative: begin
                push_val_q <= {16'h0000, pc_q + PER_INSN_LEN + off_full};
                n_q <= PTR_BYTES;
                io_addr_q <= {pbank_q, pc_q + 16'h0002};
                io_next_q <= st_data;
                state_q <= st_io;
              end
              op_stack_rel, op_stack_rel_ind: begin
                base_q <= {STACK_BANK, sp_q + {8'h00, rdata}};
                io_next_q <= (op_q == op_stack_rel) ? st_data : st_ptr;
                state_q <= st_io;
              end
              default: begin
                // Destination bank is fetched first, so it sits in the low byte.
                {sbank_q, mdst_q} <= off_full;
                state_q <= st_mvrd;
              end
            endcase
          end
        end
        st_ptr: begin
          ptr_q <= rdata;
          k_q <= k_next[1:0];
          if (k_q == 2'h1) begin
            k_q <= 2'h0;
            if (op_q == op_push_indirect) begin
              push_val_q <= {16'h0000, ptr_full};
              n_q <= PTR_BYTES;
              base_q <= {STACK_BANK, sp_q};
              state_q <= st_data;
            end else begin
              base_q <= {dbank_q, ptr_full} + y_q[23:0];
              io_left_q <= 2'h1;
              io_addr_q <= base_q + 24'h000001;
              io_next_q <= st_data;
              state_q <= st_io;
            end
          end
        end
        st_data: begin
          if (!wr_q) result_q <= result_q | ({24'h000000, rdata} << {k_q, 3'b000});
          k_q <= k_next[1:0];
          if (data_last) begin
            k_q <= 2'h0;
            done_q <= 1'b1;
            state_q <= st_idle;
            if (down_q) sp_q <= sp_q - n16;
            else if (op_q == op_pull) sp_q <= sp_q + n16;
          end
        end
        st_bank: begin
          pbank_q <= rdata;
          sp_q <= sp_q + RTL_BANK_OFFSET;
          pc_next_q <= pc_q;
          state_q <= st_next;
        end
        st_next: begin
          done_q <= 1'b1;
          state_q <= st_idle;
        end
        st_mvrd: begin
          mv_byte_q <= rdata;
          state_q <= st_mvwr;
        end
        st_mvwr: begin
          x_q <= x_q - 32'h00000001;
          y_q <= y_q - 32'h00000001;
          acc_q <= acc_q - 32'h00000001;
          io_left_q <= 2'h2;
          io_addr_q <= {mdst_q, y_q[15:0]};
          io_next_q <= (acc_q == 32'h00000000) ? st_next : st_fetch;
          pc_next_q <= pc_q + (native_q ? MOVE_NEXT_NATIVE : MOVE_NEXT_EMU);
          state_q <= st_io;
        end
        st_io: begin
          io_left_q <= io_left_q - 2'h1;
          if (io_left_q == 2'h1) state_q <= io_next_q;
        end
        default: state_q <= st_idle;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks on the bus sequence; they watch this block's state and outputs, plus the start, op and rdata inputs.
  qual_io_a: assert property ((state_q == st_io) |-> (!data_valid_out && !program_valid_out))
    else $error("internal cycle carries a valid qualifier");
  rtl_bank_a: assert property ((start && !busy && op == op_return_long) |=>
    (bus_addr == {STACK_BANK, sp_q + RTL_BANK_OFFSET}) ##1
    (program_valid_out && data_valid_out && pbank_q == $past(rdata)))
    else $error("return long bank read or refetch wrong");
  push_seq_a: assert property ((start && !busy && op == op_push) |=> (state_q == st_fetch) ##1
    (state_q == st_io && bus_addr == {pbank_q, pc_q + 16'h0001}) ##1
    (in_data && !read_not_write && bus_addr == {STACK_BANK, sp_q}))
    else $error("push sequence wrong");
  pull_wide_a: assert property ((state_q == st_fetch && op_q == op_pull && n_q == 3'h4) |->
    ##3 (in_data && read_not_write) [*4] ##1 (done && state_q == st_idle))
    else $error("wide pull length wrong");
  pei_ptr_a: assert property ((state_q == st_ptr) |->
    (data_valid_out && !program_valid_out && bus_addr[23:16] == STACK_BANK))
    else $error("pointer read not a bank zero data cycle");
  pea_len_a: assert property ((start && !busy && op == op_push_absolute) |-> ##6 done)
    else $error("push absolute not five cycles");
  per_len_a: assert property ((start && !busy && op == op_push_relative) |-> ##7 done)
    else $error("push relative not six cycles");
  per_high_a: assert property ((in_data && op_q == op_push_relative && k_q == 2'h0) |->
    (wdata == push_val_q[15:8] && push_val_q[15:0] == pc_q + PER_INSN_LEN + off_q))
    else $error("push relative high byte wrong");
  sr_seq_a: assert property ((start && !busy && op == op_stack_rel) |->
    ##3 (state_q == st_io) ##1 (in_data && bus_addr[23:16] == STACK_BANK))
    else $error("stack relative sequence wrong");
  sri_seq_a: assert property ((state_q == st_ptr && k_q == 2'h1 && op_q == op_stack_rel_ind) |=>
    (state_q == st_io) ##1 (in_data && bus_addr == base_q))
    else $error("indirect indexed sequence wrong");
  move_ops_a: assert property ((state_q == st_fetch && op_q == op_block_move_descending &&
    !native_q) |=> (program_valid_out && bus_addr == {pbank_q, pc_q + 16'h0001}) ##1
    (program_valid_out && bus_addr == {pbank_q, pc_q + 16'h0002}) ##1 (state_q == st_mvrd))
    else $error("block move operand fetch wrong");
  move_native_a: assert property ((state_q == st_fetch && op_q == op_block_move_descending &&
    native_q) |=> (state_q == st_mvrd))
    else $error("native block move kept operand cycles");
  move_byte_a: assert property ((state_q == st_mvrd) |=> (!read_not_write && wdata ==
    $past(rdata)) ##1 (state_q == st_io) [*2] ##1 (state_q == st_fetch || state_q == st_next))
    else $error("block move byte sequence wrong");
  move_dec_a: assert property ((state_q == st_mvwr) |=>
    (x_q == $past(x_q) - 32'h00000001 && y_q == $past(y_q) - 32'h00000001))
    else $error("block move indexes not decremented");
  move_loop_a: assert property ((state_q == st_mvwr && acc_q != 32'h00000000) |->
    ##3 (state_q == st_fetch && bus_addr == {pbank_q, pc_q}))
    else $error("block move did not repeat at same counter");
  move_end_a: assert property ((state_q == st_mvwr && acc_q == 32'h00000000 && !native_q) |->
    ##3 (state_q == st_next && bus_addr == {pbank_q, pc_q + MOVE_NEXT_EMU}))
    else $error("block move exit fetch wrong");
  dl_extra_a: assert property ((state_q == st_opf && op_q == op_push_indirect &&
    dir_q[7:0] != 8'h00) |=> (state_q == st_io) ##1 (state_q == st_ptr))
    else $error("direct low extra cycle missing");
  pull_sp_a: assert property ((in_data && op_q == op_pull && data_last) |=>
    (sp_q == $past(sp_q) + {13'h0000, $past(n_q)}))
    else $error("stack pointer not moved after pull");

  pull_c: cover property ((state_q == st_fetch && op_q == op_pull) ##3 in_data);
  move_loop_c: cover property ((state_q == st_mvwr && acc_q != 32'h00000000) ##3
    (state_q == st_fetch));
  pei_extra_c: cover property ((state_q == st_opf && op_q == op_push_indirect) ##1 (state_q == st_io));
  rtl_c: cover property ((state_q == st_bank) ##1 (state_q == st_next));

endmodule : stack_block_move_bus_sequencer

// >>> mem_model.sv
// Memory model for the far side of the stack and block move bus sequencer.
// Assumes reads are answered in the same cycle the address is presented.
`timescale 1ns/100ps
module mem_model (
  input wire logic ref_clk,
  input wire logic [23:0] bus_addr,
  input wire logic read_not_write,
  input wire logic data_valid_out,
  input wire logic program_valid_out,
  output logic [7:0] rdata
);
  logic [7:0] last_q;
  wire logic read_cycle;
  ////////////////////////////////////////////////////////////////////////////////
  // Contents follow the address so that the bench can work out every byte read.
  // Writes are not stored, so a read-back would not show written data.
  assign read_cycle = read_not_write && (data_valid_out || program_valid_out);
  // Outside a read the data lines float, shown as the inverse of the last value.
  assign rdata = read_cycle ? (bus_addr[7:0] ^ bus_addr[15:8] ^ 8'h3C) : ~last_q;
  always_ff @(posedge ref_clk) begin
    last_q <= rdata;
  end
endmodule : mem_model

// >>> stack_block_move_bus_sequencer_tb.sv
// Self-checking bench for the stack and block move bus sequencer.
// Assumes the memory model answers reads in the cycle they are addressed.
`timescale 1ns/100ps
module stack_block_move_bus_sequencer_tb;
  import stack_seq_pkg::*;
  typedef struct packed {logic [23:0] a; logic dv; logic pv; logic rw; logic [7:0] wd;} cyc_type;
  localparam logic [7:0] PB = 8'h12;
  localparam logic [7:0] DB = 8'h34;
  localparam logic [15:0] PC0 = 16'h20F0;
  localparam logic [15:0] S0 = 16'h01F0;
  localparam logic [15:0] DP = 16'h0305;
  localparam logic [31:0] X0 = 32'h0000_4010;
  localparam logic [31:0] Y0 = 32'h0000_5020;
  localparam logic [31:0] RV = 32'hA1B2_C3D4;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic start = 1'b0;
  op_type op = op_push;
  logic [1:0] width = WIDTH_8;
  logic store = 1'b0;
  logic native = 1'b0;
  logic [15:0] direct_in = DP;
  logic [31:0] acc_in = 32'h0;
  logic [15:0] move_banks_in = 16'h5678;
  logic [7:0] rdata, wdata, pbank_out;
  logic busy, done, read_not_write, data_valid_out, program_valid_out;
  logic vector_pull_out, memory_lock_out;
  logic [23:0] bus_addr;
  logic [15:0] sp_out;
  logic [31:0] x_out, y_out, acc_out, result_out;
  int mismatches = 0;
  int check_count = 0;
  cyc_type q[$];
  always #2.5 ref_clk = ~ref_clk;
  stack_block_move_bus_sequencer stack_block_move_bus_sequencer_i (.ref_clk(ref_clk),
    .resetn(resetn), .start(start), .op(op), .width(width), .store(store), .native(native),
    .pc_in(PC0), .sp_in(S0), .direct_in(direct_in), .x_in(X0), .y_in(Y0), .acc_in(acc_in),
    .pbank_in(PB), .dbank_in(DB), .move_banks_in(move_banks_in), .reg_in(RV), .rdata(rdata),
    .busy(busy), .done(done), .bus_addr(bus_addr), .wdata(wdata),
    .read_not_write(read_not_write), .data_valid_out(data_valid_out),
    .program_valid_out(program_valid_out), .vector_pull_out(vector_pull_out),
    .memory_lock_out(memory_lock_out), .sp_out(sp_out), .x_out(x_out), .y_out(y_out),
    .acc_out(acc_out), .pbank_out(pbank_out), .result_out(result_out));
  mem_model mem_model_i (.ref_clk(ref_clk), .bus_addr(bus_addr),
    .read_not_write(read_not_write), .data_valid_out(data_valid_out),
    .program_valid_out(program_valid_out), .rdata(rdata));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] pat(input logic [23:0] a);
    pat = a[7:0] ^ a[15:8] ^ 8'h3C;
  endfunction : pat
  function automatic logic [23:0] z(input logic [15:0] a);
    z = {STACK_BANK, a};
  endfunction : z
  function automatic logic [23:0] p(input logic [15:0] a);
    p = {PB, a};
  endfunction : p
  task automatic ck(input logic ok, input string m);
    check_count++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("BAD %0t %s", $time, m);
    end
  endtask : ck
  task automatic e(input logic [23:0] a, input logic dv, pv, rw, input logic [7:0] wd);
    q.push_back({a, dv, pv, rw, wd});
  endtask : e
  task automatic f(input logic [23:0] a); e(a, 1'b1, 1'b1, 1'b1, 8'h00); endtask : f
  task automatic o(input logic [23:0] a); e(a, 1'b0, 1'b1, 1'b1, 8'h00); endtask : o
  task automatic n(input logic [23:0] a); e(a, 1'b0, 1'b0, 1'b1, 8'h00); endtask : n
  task automatic r(input logic [23:0] a); e(a, 1'b1, 1'b0, 1'b1, 8'h00); endtask : r
  task automatic w(input logic [23:0] a, input logic [7:0] d);
    e(a, 1'b1, 1'b0, 1'b0, d);
  endtask : w
  // Walks the queued bus cycles one per clock, then expects the done pulse.
  task automatic go(input string nm, input logic [15:0] sp);
    cyc_type c;
    for (int i = 0; i < q.size(); i++) begin
      @(posedge ref_clk);
      if (i == 0) start <= 1'b0;
      #1;
      c = q[i];
      ck(bus_addr === c.a && data_valid_out === c.dv && program_valid_out === c.pv &&
         read_not_write === c.rw && (c.rw || wdata === c.wd) && busy === 1'b1, "bus cycle");
      ck(vector_pull_out === 1'b1 && memory_lock_out === 1'b1, "pull or lock low");
    end
    @(posedge ref_clk);
    #1;
    ck(done === 1'b1 && busy === 1'b0 && sp_out === sp, "done or stack pointer");
    q.delete();
    $display("%s finished", nm);
  endtask : go
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_stack;
    logic [15:0] b, a;
    logic [15:0] v;
    logic [23:0] ea;
    @(posedge ref_clk); op <= op_push; width <= WIDTH_16; start <= 1'b1;
    f(p(PC0)); n(p(PC0 + 16'h1)); w(z(S0), RV[15:8]); w(z(S0 - 16'h1), RV[7:0]);
    go("push", S0 - 16'h2);
    @(posedge ref_clk); op <= op_pull; width <= WIDTH_32; start <= 1'b1;
    f(p(PC0)); n(p(PC0 + 16'h1)); n(p(PC0 + 16'h1));
    for (int k = 1; k < 5; k++) r(z(S0 + 16'(k)));
    go("pull", S0 + 16'h4);
    ck(result_out === {pat(z(S0 + 16'h4)), pat(z(S0 + 16'h3)), pat(z(S0 + 16'h2)),
       pat(z(S0 + 16'h1))}, "pulled value");
    for (int k = 0; k < 2; k++) begin
      @(posedge ref_clk); op <= op_push_indirect; direct_in <= k ? (DP & 16'hFF00) : DP;
      start <= 1'b1;
      b = (k ? (DP & 16'hFF00) : DP) + {8'h00, pat(p(PC0 + 16'h1))};
      f(p(PC0)); o(p(PC0 + 16'h1));
      if (k == 0) n(p(PC0 + 16'h1));
      r(z(b)); r(z(b + 16'h1)); w(z(S0), pat(z(b + 16'h1))); w(z(S0 - 16'h1), pat(z(b)));
      go("push indirect", S0 - 16'h2);
    end
    @(posedge ref_clk); op <= op_push_absolute; start <= 1'b1;
    f(p(PC0)); o(p(PC0 + 16'h1)); o(p(PC0 + 16'h2));
    w(z(S0), pat(p(PC0 + 16'h2))); w(z(S0 - 16'h1), pat(p(PC0 + 16'h1)));
    go("push absolute", S0 - 16'h2);
    // The offset low byte here makes the low sum carry into the high byte.
    v = PC0 + PER_INSN_LEN + {pat(p(PC0 + 16'h2)), pat(p(PC0 + 16'h1))};
    @(posedge ref_clk); op <= op_push_relative; start <= 1'b1;
    f(p(PC0)); o(p(PC0 + 16'h1)); o(p(PC0 + 16'h2)); n(p(PC0 + 16'h2));
    w(z(S0), v[15:8]); w(z(S0 - 16'h1), v[7:0]);
    go("push relative", S0 - 16'h2);
    a = S0 + {8'h00, pat(p(PC0 + 16'h1))};
    @(posedge ref_clk); op <= op_stack_rel; width <= WIDTH_16; store <= 1'b1; start <= 1'b1;
    f(p(PC0)); o(p(PC0 + 16'h1)); n(p(PC0 + 16'h1));
    w(z(a), RV[7:0]); w(z(a + 16'h1), RV[15:8]);
    go("stack relative", S0);
    ea = {DB, pat(z(a + 16'h1)), pat(z(a))} + Y0[23:0];
    @(posedge ref_clk); op <= op_stack_rel_ind; width <= WIDTH_8; store <= 1'b0; start <= 1'b1;
    f(p(PC0)); o(p(PC0 + 16'h1)); n(p(PC0 + 16'h1)); r(z(a)); r(z(a + 16'h1));
    n(z(a + 16'h1)); r(ea);
    go("stack relative indirect", S0);
    ck(result_out === {24'h000000, pat(ea)}, "indirect indexed value");
    @(posedge ref_clk); op <= op_return_long; start <= 1'b1;
    r(z(S0 + RTL_BANK_OFFSET)); f({pat(z(S0 + RTL_BANK_OFFSET)), PC0});
    go("return long", S0 + 16'h3);
    ck(pbank_out === pat(z(S0 + RTL_BANK_OFFSET)), "program bank");
  endtask : t_stack
  // Destination starts above the source, so the descending move is the right one.
  task automatic t_move(input logic nat, input logic [31:0] cnt);
    logic [7:0] sb, db;
    logic [15:0] kk;
    sb = nat ? move_banks_in[7:0] : pat(p(PC0 + 16'h2));
    db = nat ? move_banks_in[15:8] : pat(p(PC0 + 16'h1));
    @(posedge ref_clk); op <= op_block_move_descending; native <= nat; acc_in <= cnt;
    start <= 1'b1;
    for (int k = 0; k <= cnt; k++) begin
      kk = 16'(k);
      f(p(PC0));
      if (!nat) begin
        o(p(PC0 + 16'h1)); o(p(PC0 + 16'h2));
      end
      r({sb, X0[15:0] - kk}); w({db, Y0[15:0] - kk}, pat({sb, X0[15:0] - kk}));
      n({db, Y0[15:0] - kk}); n({db, Y0[15:0] - kk});
    end
    f(p(PC0 + (nat ? MOVE_NEXT_NATIVE : MOVE_NEXT_EMU)));
    go("block move", S0);
    ck(x_out === X0 - cnt - 1 && y_out === Y0 - cnt - 1, "index registers");
    ck(acc_out === cnt - cnt - 32'h1, "byte count");
  endtask : t_move
  ////////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    #200000;
    mismatches++;
    report_and_stop;
  end
  initial begin
    repeat (2) @(posedge ref_clk);
    resetn <= 1'b1;
    #1;
    ck(busy === 1'b0 && done === 1'b0 && bus_addr === 24'h0 && read_not_write === 1'b1 &&
       data_valid_out === 1'b0 && program_valid_out === 1'b0, "idle after reset");
    t_stack;
    t_move(1'b0, 32'h1);
    t_move(1'b1, 32'h0);
    report_and_stop;
  end
endmodule : stack_block_move_bus_sequencer_tb
